// ### tb_top.sv
// testbench: random writes and oscillator samples, queued expectations
`timescale 1ns/1ps
module tb_top;
    logic clk_in = 0, rstn_in = 0, m = 0, g, s;
    voice_mod_pkg::reg_wr_s r = '0;
    logic [7:0] o1 = 0, o3 = 0, cr, w1, w3, ct = 0, md = 0, t;
    logic [23:0] q[$], n;
    int num_errors = 0, checked = 0, seed = 32'h6da223c6, i;
    always #50 clk_in = ~clk_in;
    voice_mod i_dut (.clk_in, .rstn_in, .reg_wr_in(r), .osc1_tri_in(o1),
        .osc3_tri_in(o3), .osc3_msb_in(m), .ctrl_rd_out(cr), .gate1_out(g),
        .sync1_out(s), .voice1_wave_out(w1), .voice3_wave_out(w3));
    task end_of_test;
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task chk(input string nm, input [7:0] e, a);
        checked++;
        if (e !== a) begin
            num_errors++;
            $display("unexpected %s exp %h got %h", nm, e, a);
        end
    endtask
    // model runs one step behind the write, as the outputs do
    task drive(input bit e, input [1:0] k, input [7:0] d);
        @(negedge clk_in);
        r.wr = e | 1'($random(seed));
        r.data = d;
        r.addr = k == 0 ? 5'h04 : k == 1 ? 5'h18 : 5'($random(seed));
        {m, o3, o1} = 17'($random(seed));
        t = ct[3] ? o1 ^ {8{m}} : o1;
        t = ct[4] ? t : 8'h00;
        if (ct[1]) t = t & o3;
        q.push_back({ct, t, md[7] ? 8'h00 : o3});
        if (r.wr && r.addr == 5'h04) ct = d;
        if (r.wr && r.addr == 5'h18) md = d;
    endtask
    always @(posedge clk_in) if (q.size() > 0) begin
        #1 n = q.pop_front();
        chk("ctrl", n[23:16], cr);
        chk("gate", n[16], g);
        chk("sync", n[17], s);
        chk("wave1", n[15:8], w1);
        chk("wave3", n[7:0], w3);
    end
    initial begin
        repeat (3) @(posedge clk_in);
        @(negedge clk_in) rstn_in = 1;
        @(posedge clk_in);
        drive(1, 0, 8'h13);
        drive(1, 0, 8'h15);
        drive(1, 1, 8'h80);
        drive(1, 3, 8'hFF);
        for (i = 0; i < 400; i++) drive(0, i[1:0], 8'($random(seed)));
        repeat (2) @(posedge clk_in);
        #2 end_of_test;
    end
    // about 410 cycles expected, so 2000 is ample
    initial begin
        #200000 num_errors++;
        end_of_test;
    end
endmodule

// ### voice_mod.sv
// voice 1 sync / ring modulation combiner with voice 3 mute
//
// Contract
// RULE1 - sync bit set: voice 1 is synchronized to voice 3.
// RULE2 - sync active: output is AND of both waveforms, zero if either zero.
// RULE3 - control bit 0 gates voice 1 whatever modulation is chosen.
// RULE4 - control bit 4 selects oscillator 1 triangle; sync/ring may join.
// RULE5 - ring bit set: ring mix of oscillators 1 and 3 replaces triangle.
// RULE6 - gate, sync and triangle written together start gated synced sound.
// RULE7 - top bit of mode/volume register mutes voice 3 audio.
// RULE8 - one control write updates all bits together, effective next sample.
`timescale 1ns/1ps

module voice_mod (
    // clock and reset
    input  wire logic                               clk_in,
    input  wire logic                               rstn_in,
    // register write port
    input  wire voice_mod_pkg::reg_wr_s             reg_wr_in,
    // oscillator waveforms
    input  wire logic [voice_mod_pkg::WAVE_W-1:0]   osc1_tri_in,
    input  wire logic [voice_mod_pkg::WAVE_W-1:0]   osc3_tri_in,
    input  wire logic                               osc3_msb_in,
    // register readback
    output logic [voice_mod_pkg::DATA_W-1:0]        ctrl_rd_out,
    // voice outputs
    output logic                                    gate1_out,
    output logic                                    sync1_out,
    output logic [voice_mod_pkg::WAVE_W-1:0]        voice1_wave_out,
    output logic [voice_mod_pkg::WAVE_W-1:0]        voice3_wave_out
);

    ////////////////////////////////////////////////////////////////////////
    // storage

    logic [voice_mod_pkg::DATA_W-1:0] ctrl_r;
    logic [voice_mod_pkg::DATA_W-1:0] mode_r;

    ////////////////////////////////////////////////////////////////////////
    // decode and combination nets

    logic                             ctrl_hit;
    logic                             mode_hit;
    voice_mod_pkg::voice1_ctrl_s      v1;
    logic                             mute3;
    logic [voice_mod_pkg::WAVE_W-1:0] ring_mask;
    wire  [voice_mod_pkg::WAVE_W-1:0] v1_nxt;
    wire  [voice_mod_pkg::WAVE_W-1:0] v3_nxt;
    logic                             gate_nxt;
    logic                             sync_nxt;
    logic [voice_mod_pkg::DATA_W-1:0] ctrl_rd_nxt;

    ////////////////////////////////////////////////////////////////////////
    // register write decode

    // unmapped offsets are dropped with no sign, as the host expects
    always_comb begin
        ctrl_hit = 1'h0;
        mode_hit = 1'h0;
        if (reg_wr_in.wr) begin
            if (reg_wr_in.addr == voice_mod_pkg::VOICE1_CTRL_OFS) begin
                ctrl_hit = 1'h1;
            end
            if (reg_wr_in.addr == voice_mod_pkg::MODE_VOL_OFS) begin
                mode_hit = 1'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    // whole byte stored in one edge so no half-updated mode is seen
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ctrl_r <= voice_mod_pkg::CTRL_RESET;
        end else if (ctrl_hit) begin
            ctrl_r <= reg_wr_in.data; // see RULE8 see RULE6
        end
    end

    // only the mute bit matters here; filter and volume bits live elsewhere
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mode_r <= voice_mod_pkg::MODE_RESET;
        end else if (mode_hit) begin
            mode_r <= reg_wr_in.data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control field decode

    always_comb begin
        v1         = '0;
        v1.gate    = ctrl_r[voice_mod_pkg::GATE_BIT];
        v1.sync_en = ctrl_r[voice_mod_pkg::SYNC_BIT];
        v1.ring_en = ctrl_r[voice_mod_pkg::RING_BIT];
        v1.tri_sel = ctrl_r[voice_mod_pkg::TRI_BIT];
    end

    // voice 3 mute is a plain level; no write sequencing is needed
    always_comb begin
        mute3 = mode_r[voice_mod_pkg::MUTE3_BIT];
    end

    ////////////////////////////////////////////////////////////////////////
    // waveform combination, one slice per sample bit

    // ring: voice 3 msb flips every triangle bit, a cheap xor
    // stand-in for a true multiplier
    assign ring_mask = {voice_mod_pkg::WAVE_W{osc3_msb_in}};

    for (genvar b = 0; b < voice_mod_pkg::WAVE_W; b++) begin : g_bit
        logic ring_bit;
        logic tri_bit;
        logic sel_bit;
        logic and_bit;
        logic out_bit;
        logic v3_bit;

        // ring replaces the plain triangle when selected
        always_comb begin
            ring_bit = osc1_tri_in[b] ^ ring_mask[b];
            tri_bit  = osc1_tri_in[b];
            if (v1.ring_en) begin
                tri_bit = ring_bit; // see RULE5
            end
        end

        // triangle select may be combined with either modulator
        always_comb begin
            sel_bit = voice_mod_pkg::WAVE_ZERO[b];
            if (v1.tri_sel) begin
                sel_bit = tri_bit; // see RULE4
            end
        end

        // sync: and with voice 3, so a zero on either side gives zero
        always_comb begin
            and_bit = sel_bit & osc3_tri_in[b];
            out_bit = sel_bit;
            if (v1.sync_en) begin
                out_bit = and_bit; // see RULE1 see RULE2
            end
        end

        // muted voice 3 still feeds the modulators above
        always_comb begin
            v3_bit = osc3_tri_in[b];
            if (mute3) begin
                v3_bit = voice_mod_pkg::WAVE_ZERO[b]; // see RULE7
            end
        end

        assign v1_nxt[b] = out_bit;
        assign v3_nxt[b] = v3_bit;
    end

    ////////////////////////////////////////////////////////////////////////
    // output next values

    always_comb begin
        gate_nxt = v1.gate; // see RULE3
    end

    always_comb begin
        sync_nxt = v1.sync_en; // see RULE1
    end

    always_comb begin
        ctrl_rd_nxt = ctrl_r;
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs, each straight from its own flip-flop

    // one register stage keeps every output glitch free toward the mixer
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            voice1_wave_out <= voice_mod_pkg::WAVE_ZERO;
        end else begin
            voice1_wave_out <= v1_nxt;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            voice3_wave_out <= voice_mod_pkg::WAVE_ZERO;
        end else begin
            voice3_wave_out <= v3_nxt;
        end
    end

    // gate follows bit 0 whatever waveform or modulator is chosen
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            gate1_out <= voice_mod_pkg::CTRL_RESET[voice_mod_pkg::GATE_BIT];
        end else begin
            gate1_out <= gate_nxt;
        end
    end

    // sync flag tells the oscillator logic to follow voice 3
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sync1_out <= voice_mod_pkg::CTRL_RESET[voice_mod_pkg::SYNC_BIT];
        end else begin
            sync1_out <= sync_nxt;
        end
    end

    // readback lags the register by one cycle, like every other output
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ctrl_rd_out <= voice_mod_pkg::CTRL_RESET;
        end else begin
            ctrl_rd_out <= ctrl_rd_nxt;
        end
    end

endmodule

// ### voice_mod_pkg.sv
// package: register map, field positions and carriers for voice modulation
package voice_mod_pkg;

    localparam int unsigned ADDR_W = 5;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned WAVE_W = 8;

    // register offsets
    localparam logic [ADDR_W-1:0] VOICE1_CTRL_OFS = 5'h04;
    localparam logic [ADDR_W-1:0] MODE_VOL_OFS    = 5'h18;

    // voice 1 control fields
    localparam int unsigned GATE_BIT = 0;
    localparam int unsigned SYNC_BIT = 1;
    localparam int unsigned RING_BIT = 3;
    localparam int unsigned TRI_BIT  = 4;

    // mode/volume fields
    localparam int unsigned MUTE3_BIT = 7;

    localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;
    localparam logic [DATA_W-1:0] MODE_RESET = 8'h00;
    localparam logic [WAVE_W-1:0] WAVE_ZERO  = 8'h00;

    // decoded voice 1 control
    typedef struct packed {
        logic tri_sel;
        logic ring_en;
        logic sync_en;
        logic gate;
    } voice1_ctrl_s;

    // register write port
    typedef struct packed {
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } reg_wr_s;

endpackage

// ### voice_mod_properties.sv
// checker: timing and value properties of the voice modulation outputs
`timescale 1ns/1ps
module voice_mod_chk (
    // design ports, observed only
    input wire logic                   clk_in, rstn_in, osc3_msb_in,
    input wire voice_mod_pkg::reg_wr_s reg_wr_in,
    input wire logic [7:0]             osc1_tri_in, osc3_tri_in, ctrl_rd_out,
    input wire logic [7:0]             voice1_wave_out, voice3_wave_out,
    input wire logic                   gate1_out, sync1_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    // output bits stand one register behind the control register
    wire [7:0] c = ctrl_rd_out, w = voice1_wave_out;
    wire wr4 = reg_wr_in.wr && reg_wr_in.addr == 5'h04;
    wire mu = reg_wr_in.wr && reg_wr_in.addr == 5'h18 && reg_wr_in.data[7];
    property p_wr; wr4 |-> ##2 c == $past(reg_wr_in.data, 2); endproperty
    a_wr: assert property (p_wr) else $error("ctrl write lost");
    property p_g; gate1_out == c[0]; endproperty
    a_g: assert property (p_g) else $error("gate wrong");
    property p_s; sync1_out == c[1]; endproperty
    a_s: assert property (p_s) else $error("sync wrong");
    property p_an; c[1] |-> (w & ~$past(osc3_tri_in)) == 8'h00; endproperty
    a_an: assert property (p_an) else $error("sync and");
    property p_tr; c[4:1] == 4'h8 |-> w == $past(osc1_tri_in); endproperty
    a_tr: assert property (p_tr) else $error("triangle");
    property p_rg; c[4:1] == 4'hC |->
        w == ($past(osc1_tri_in) ^ {8{$past(osc3_msb_in)}}); endproperty
    a_rg: assert property (p_rg) else $error("ring");
    property p_nt; !c[4] |-> w == 8'h00; endproperty
    a_nt: assert property (p_nt) else $error("no wave");
    property p_mu; mu |-> ##2 voice3_wave_out == 8'h00; endproperty
    a_mu: assert property (p_mu) else $error("mute");
    cover property (c == 8'h13);
    cover property (c[4:3] == 2'h3);
    cover property (mu);
endmodule
////////////////////////////////////////////////////////////
bind voice_mod voice_mod_chk i_chk (
    .clk_in          (clk_in),
    .rstn_in         (rstn_in),
    .osc3_msb_in     (osc3_msb_in),
    .reg_wr_in       (reg_wr_in),
    .osc1_tri_in     (osc1_tri_in),
    .osc3_tri_in     (osc3_tri_in),
    .ctrl_rd_out     (ctrl_rd_out),
    .voice1_wave_out (voice1_wave_out),
    .voice3_wave_out (voice3_wave_out),
    .gate1_out       (gate1_out),
    .sync1_out       (sync1_out)
);
